/* File: design/dmp_top.sv */
// one channel: mask/inversion line handling and bank closing, apb register access
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module dmp_top
   import dmp_pkg::*;
#(
   parameter bit MRR_INV_SUPPORT = 1'b1,
   parameter int CNT_W           = 8
)(
   input  wire logic                  SYS_CLK,
   input  wire logic                  RESET,
   input  wire logic                  CLK_EN,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [7:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   input  wire logic [3:0]            PSTRB,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire logic                  LINK_CK,
   input  wire logic [3:0]            CMD_CODE,
   input  wire logic [5:0]            CMD_CA,
   input  wire logic [15:0]           DQ_IN,
   input  wire logic [1:0]            MIV_IN,
   output logic      [15:0]           DQ_OUT,
   output logic                       DQ_OE,
   output logic      [1:0]            MIV_OUT,
   output logic      [1:0]            MIV_OE,
   output logic                       MIV_RX_ON,
   output logic                       ARR_WR_STB,
   output logic      [15:0]           ARR_WR_DATA,
   output logic      [1:0]            ARR_WR_BE,
   output logic      [2:0]            ARR_WR_BANK,
   output logic                       ARR_GROUP_END,
   input  wire logic [15:0]           ARR_RD_DATA,
   output logic      [NUM_BANKS-1:0]  BANK_OPEN
);
   import dmp_pkg::*;

   localparam int PIN_W = 29;

   // refuse counter widths that cannot hold the timing fields
   if (CNT_W < 8 || CNT_W > 16)
   begin : g_chk
      $error("dmp_top: CNT_W must be 8 to 16");
   end

   typedef struct packed {
      logic [PIN_W-1:0]                 s1;
      logic [PIN_W-1:0]                 s2;
      logic [PIN_W-1:0]                 s3;
      logic [PIN_W-1:0]                 pin;
      logic [7:0]                       mode3;
      logic [7:0]                       mode13;
      logic                             bl32;
      logic [31:0]                      timing;
      logic [31:0]                      prdata;
      logic                             pslverr;
      dmp_phase_t                       phase;
      dmp_cmd_t                         kind;
      logic [3:0]                       lat;
      logic [5:0]                       beat;
      logic [2:0]                       bank;
      logic [31:0][1:0]                 fifo;
      logic [NUM_BANKS-1:0]             open;
      logic [NUM_BANKS-1:0]             pend;
      logic [NUM_BANKS-1:0][CNT_W-1:0]  ras;
      logic [NUM_BANKS-1:0][CNT_W-1:0]  apc;
      logic [15:0]                      dq_out;
      logic                             dq_oe;
      logic [1:0]                       miv_out;
      logic [1:0]                       miv_oe;
      logic                             wr_stb;
      logic [15:0]                      wr_data;
      logic [1:0]                       wr_be;
      logic                             grp_end;
   } dmp_state_t;

   dmp_state_t s;
   dmp_state_t next_s;

   // count of ones in a byte
   function automatic logic [3:0] ones8(input logic [7:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         c = c + {3'h0, v[i]};
      end
      return c;
   endfunction

   // settled pin values and derived controls
   logic             lk_now;
   logic             lk_old;
   logic             lk_rise;
   logic             lk_edge;
   logic [3:0]       cmd_raw;
   logic [5:0]       ca;
   logic [15:0]      dq;
   logic [1:0]       miv;
   logic             mask_en;
   logic             winv_en;
   logic             rinv_en;
   logic [3:0]       wl;
   logic [3:0]       rl;
   logic [CNT_W-1:0] read_to_close_cycles;
   logic [CNT_W-1:0] nwr;
   logic [CNT_W-1:0] nras;
   logic [5:0]       beats;
   logic [CNT_W-1:0] rd_close;
   logic [CNT_W-1:0] wr_close;
   logic             apb_setup;
   logic             apb_write;

   assign lk_old  = s.pin[PIN_W-1];
   assign mask_en = s.mode13[MR13_MASK_BIT];
   assign winv_en = s.mode3[MR3_WINV_BIT];
   assign rinv_en = s.mode3[MR3_RINV_BIT];
   assign wl      = s.timing[TIM_WL_LSB +: 4];
   assign rl      = s.timing[TIM_RL_LSB +: 4];
   assign read_to_close_cycles    = CNT_W'(s.timing[TIM_RTP_LSB +: 8]);
   assign nwr     = CNT_W'(s.timing[TIM_WR_LSB +: 8]);
   assign nras    = CNT_W'(s.timing[TIM_RAS_LSB +: 8]);
   assign beats   = s.bl32 ? BEATS_32 : BEATS_16;
   // read close counts from half burst minus eight, so burst 32 adds eight
   assign rd_close = read_to_close_cycles + (s.bl32 ? CNT_W'(BL32_EXTRA) : '0);
   // write close: latency plus half burst plus one plus recovery
   assign wr_close = CNT_W'(wl) + CNT_W'(beats[5:1]) + CNT_W'(WR_CLOSE_ADD) + nwr;
   assign apb_setup = PSEL & ~PENABLE;
   assign apb_write = PSEL & PENABLE & PWRITE;

   // next state of the whole block
   always_comb
   begin
      next_s = s;
      // three-stage pin capture, a bit settles when stages two and three agree
      next_s.s1  = {LINK_CK, CMD_CODE, CMD_CA, DQ_IN, MIV_IN};
      next_s.s2  = s.s1;
      next_s.s3  = s.s2;
      next_s.pin = (s.s2 & ~(s.s2 ^ s.s3)) | (s.pin & (s.s2 ^ s.s3));
      lk_now  = next_s.pin[PIN_W-1];
      lk_rise = lk_now & ~lk_old;
      lk_edge = lk_now ^ lk_old;
      cmd_raw = next_s.pin[27:24];
      ca      = next_s.pin[23:18];
      dq      = next_s.pin[17:2];
      miv     = next_s.pin[1:0];
      next_s.wr_stb  = 1'b0;
      next_s.grp_end = 1'b0;

      // apb: read data and error prepared in the setup cycle
      if (apb_setup)
      begin
         next_s.pslverr = 1'b0;
         case (PADDR)
            ADDR_MODE3:  next_s.prdata = {24'h0, s.mode3};
            ADDR_MODE13: next_s.prdata = {24'h0, s.mode13};
            ADDR_TIMING: next_s.prdata = s.timing;
            ADDR_MODE1:  next_s.prdata = {31'h0, s.bl32};
            ADDR_STATUS: next_s.prdata = {15'h0, (s.phase != PH_IDLE), s.pend, s.open};
            default:
            begin
               next_s.prdata  = 32'h0;
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      // apb writes honour byte strobes
      if (apb_write)
      begin
         case (PADDR)
            ADDR_MODE3:  if (PSTRB[0]) next_s.mode3 = PWDATA[7:0];
            ADDR_MODE13: if (PSTRB[0]) next_s.mode13 = PWDATA[7:0];
            ADDR_MODE1:  if (PSTRB[0]) next_s.bl32 = PWDATA[MR1_BL32_BIT];
            ADDR_TIMING:
            begin
               for (int b = 0; b < 4; b++)
               begin
                  if (PSTRB[b]) next_s.timing[8*b +: 8] = PWDATA[8*b +: 8];
               end
            end
            default: ;
         endcase
      end

      // per-bank timers on each link rising edge
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         if (lk_rise)
         begin
            if (s.open[b] && s.ras[b] != '1) next_s.ras[b] = s.ras[b] + 1'b1;
            if (s.apc[b] != '0) next_s.apc[b] = s.apc[b] - 1'b1;
            // internal close waits for its delay and the row active minimum
            if (s.pend[b] && s.apc[b] <= CNT_W'(1) && s.ras[b] >= nras)
            begin
               next_s.pend[b] = 1'b0;
               next_s.open[b] = 1'b0;
            end
         end
      end

      // command decode on the link rising edge
      if (lk_rise)
      begin
         case (cmd_raw)
            CMD_ACT:
            begin
               next_s.open[ca[2:0]] = 1'b1;
               next_s.ras[ca[2:0]]  = '0;
               next_s.pend[ca[2:0]] = 1'b0;
            end
            CMD_PRE:
            begin
               if (ca[CA_FLAG_BIT])
               begin
                  next_s.open = '0;
                  next_s.pend = '0;
               end
               else
               begin
                  next_s.open[ca[2:0]] = 1'b0;
                  next_s.pend[ca[2:0]] = 1'b0;
               end
            end
            CMD_RD, CMD_WR, CMD_MWR:
            begin
               // auto-close flag arms the close, flag low leaves the bank open
               if (ca[CA_FLAG_BIT])
               begin
                  next_s.pend[ca[2:0]] = 1'b1;
                  next_s.apc[ca[2:0]]  = (cmd_raw == CMD_RD) ? rd_close : wr_close;
               end
            end
            default: ;
         endcase
         // bursts start only from idle; a command during a burst moves no data
         if (s.phase == PH_IDLE)
         begin
            case (cmd_raw)
               CMD_WR, CMD_MWR, CMD_WFIFO:
               begin
                  next_s.kind  = dmp_cmd_t'(cmd_raw);
                  next_s.bank  = ca[2:0];
                  next_s.lat   = wl;
                  next_s.phase = PH_WLAT;
               end
               CMD_RD, CMD_MRR, CMD_RFIFO:
               begin
                  next_s.kind  = dmp_cmd_t'(cmd_raw);
                  next_s.lat   = rl;
                  next_s.phase = PH_RLAT;
               end
               default: ;
            endcase
         end
      end

      // burst sequencer
      case (s.phase)
         PH_IDLE: ;
         PH_WLAT, PH_RLAT:
         begin
            if (lk_rise)
            begin
               next_s.lat  = s.lat - 1'b1;
               next_s.beat = '0;
               if (s.lat <= 4'h1)
               begin
                  next_s.phase = (s.phase == PH_WLAT) ? PH_WBURST : PH_RBURST;
                  next_s.dq_oe  = (s.phase == PH_RLAT);
                  // line driven for fifo, inverting reads and any mode register read
                  next_s.miv_oe = {NUM_LANES{(s.phase == PH_RLAT) &&
                                  (s.kind == CMD_RFIFO || s.kind == CMD_MRR || rinv_en)}};
               end
            end
         end
         PH_WBURST:
         begin
            if (lk_edge)
            begin
               next_s.wr_stb  = (s.kind != CMD_WFIFO);
               next_s.wr_data = dq;
               next_s.wr_be   = 2'b11;
               for (int l = 0; l < NUM_LANES; l++)
               begin
                  case (s.kind)
                     CMD_WFIFO: next_s.fifo[s.beat][l] = miv[l];
                     CMD_WR:
                     begin
                        // without inversion the line is ignored on writes
                        if (winv_en && miv[l])
                           next_s.wr_data[8*l +: 8] = ~dq[8*l +: 8];
                     end
                     CMD_MWR:
                     begin
                        if (!winv_en)
                           next_s.wr_be[l] = ~miv[l];
                        else if (ones8({dq[8*l+7 -: 6], 2'b00}) >= MASK_ONES_MIN
                                 && !miv[l])
                           next_s.wr_be[l] = 1'b0;
                        else if (miv[l])
                           next_s.wr_data[8*l +: 8] = ~dq[8*l +: 8];
                     end
                     default: ;
                  endcase
               end
               // group boundary marks where write recovery may begin
               next_s.grp_end = (s.beat[3:0] == GROUP_LAST) && (s.kind != CMD_WFIFO);
               next_s.beat    = s.beat + 1'b1;
               if (s.beat == beats - 6'h1) next_s.phase = PH_IDLE;
            end
         end
         PH_RBURST:
         begin
            if (lk_edge)
            begin
               next_s.dq_out  = ARR_RD_DATA;
               next_s.miv_out = 2'b00;
               for (int l = 0; l < NUM_LANES; l++)
               begin
                  if (s.kind == CMD_RFIFO)
                     next_s.miv_out[l] = s.fifo[s.beat][l];
                  else if (rinv_en && (s.kind == CMD_RD || MRR_INV_SUPPORT))
                  begin
                     if (ones8(ARR_RD_DATA[8*l +: 8]) > READ_INV_MAX)
                     begin
                        next_s.dq_out[8*l +: 8] = ~ARR_RD_DATA[8*l +: 8];
                        next_s.miv_out[l]       = 1'b1;
                     end
                  end
               end
               next_s.beat = s.beat + 1'b1;
               if (s.beat == beats - 6'h1)
               begin
                  next_s.phase  = PH_IDLE;
               end
            end
            // drivers released one link edge after the last beat
            if (lk_edge && s.beat == beats)
            begin
               next_s.dq_oe  = 1'b0;
               next_s.miv_oe = 2'b00;
            end
         end
         default: next_s.phase = PH_IDLE;
      endcase
      // keep the last read beat on the pins for one more link edge
      if (s.phase == PH_RBURST && lk_edge && s.beat == beats - 6'h1)
      begin
         next_s.beat = beats;
      end
      if (s.phase == PH_IDLE && s.dq_oe && lk_edge)
      begin
         next_s.dq_oe  = 1'b0;
         next_s.miv_oe = 2'b00;
      end
   end

   // registered state, frozen while clock enable is low
   always_ff @(posedge SYS_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         s        <= '0;
         s.mode3  <= MODE3_RST;
         s.mode13 <= MODE13_RST;
         s.bl32   <= MODE1_RST;
         s.timing <= TIMING_RST;
      end
      else if (CLK_EN)
      begin
         s <= next_s;
      end
   end

   // outputs
   assign PREADY        = CLK_EN;
   assign PRDATA        = s.prdata;
   assign PSLVERR       = s.pslverr;
   assign DQ_OUT        = s.dq_out;
   assign DQ_OE         = s.dq_oe;
   assign MIV_OUT       = s.miv_out;
   assign MIV_OE        = s.miv_oe;
   // receivers on while masking or write inversion is enabled, or during a fifo training write
   assign MIV_RX_ON     = mask_en | winv_en | (s.kind == CMD_WFIFO && s.phase != PH_IDLE);
   assign ARR_WR_STB    = s.wr_stb;
   assign ARR_WR_DATA   = s.wr_data;
   assign ARR_WR_BE     = s.wr_be;
   assign ARR_WR_BANK   = s.bank;
   assign ARR_GROUP_END = s.grp_end;
   assign BANK_OPEN     = s.open;
endmodule

/* File: design/dmp_pkg.sv */
// constants, commands and states shared by the mask/inversion and bank-close block
package dmp_pkg;
   // register byte addresses on the apb bus
   localparam logic [7:0] ADDR_MODE3  = 8'h00;
   localparam logic [7:0] ADDR_MODE13 = 8'h04;
   localparam logic [7:0] ADDR_TIMING = 8'h08;
   localparam logic [7:0] ADDR_MODE1  = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // mode bit positions
   localparam int MR3_WINV_BIT  = 7;
   localparam int MR3_RINV_BIT  = 6;
   localparam int MR13_MASK_BIT = 5;
   localparam int MR1_BL32_BIT  = 0;
   // timing register fields, counted in link clock cycles
   localparam int TIM_WL_LSB   = 0;
   localparam int TIM_RL_LSB   = 4;
   localparam int TIM_RTP_LSB  = 8;
   localparam int TIM_WR_LSB   = 16;
   localparam int TIM_RAS_LSB  = 24;
   // status register fields
   localparam int STAT_OPEN_LSB = 0;
   localparam int STAT_PEND_LSB = 8;
   localparam int STAT_BUSY_BIT = 16;
   // reset values
   localparam logic [7:0]  MODE3_RST  = 8'h00;
   localparam logic [7:0]  MODE13_RST = 8'h00;
   localparam logic        MODE1_RST  = 1'b0;
   localparam logic [31:0] TIMING_RST = 32'h0406_0864;
   // command address layout
   localparam int CA_FLAG_BIT = 5;
   localparam int NUM_BANKS   = 8;
   localparam int NUM_LANES   = 2;
   // burst and threshold figures
   localparam logic [5:0] BEATS_16      = 6'h10;
   localparam logic [5:0] BEATS_32      = 6'h20;
   localparam logic [7:0] BL32_EXTRA    = 8'h08;
   localparam logic [7:0] WR_CLOSE_ADD  = 8'h01;
   localparam logic [3:0] MASK_ONES_MIN = 4'h5;
   localparam logic [3:0] READ_INV_MAX  = 4'h4;
   localparam logic [3:0] GROUP_LAST    = 4'hF;
   // commands as decoded from the command pins
   typedef enum logic [3:0] {
      CMD_NOP   = 4'h0,
      CMD_ACT   = 4'h1,
      CMD_RD    = 4'h2,
      CMD_WR    = 4'h3,
      CMD_MWR   = 4'h4,
      CMD_PRE   = 4'h5,
      CMD_MRR   = 4'h6,
      CMD_WFIFO = 4'h7,
      CMD_RFIFO = 4'h8
   } dmp_cmd_t;
   // burst sequencer states
   typedef enum logic [2:0] {
      PH_IDLE   = 3'h0,
      PH_WLAT   = 3'h1,
      PH_WBURST = 3'h2,
      PH_RLAT   = 3'h3,
      PH_RBURST = 3'h4
   } dmp_phase_t;
endpackage

/* File: tb/dmp_props.sv */
// port-level assertions for the mask/inversion and bank-close block
`timescale 1ns/1ps
module dmp_props
   import dmp_pkg::*;
(
   input wire logic                 SYS_CLK,
   input wire logic                 RESET,
   input wire logic                 CLK_EN,
   input wire logic                 PSEL,
   input wire logic                 PENABLE,
   input wire logic [7:0]           PADDR,
   input wire logic [31:0]          PRDATA,
   input wire logic                 PREADY,
   input wire logic                 PSLVERR,
   input wire logic [3:0]           CMD_CODE,
   input wire logic [5:0]           CMD_CA,
   input wire logic                 DQ_OE,
   input wire logic [1:0]           MIV_OE,
   input wire logic                 ARR_WR_STB,
   input wire logic                 ARR_GROUP_END,
   input wire logic [NUM_BANKS-1:0] BANK_OPEN
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   logic [3:0] beat_cnt;
   // stored beats since the last group boundary
   always_ff @(posedge SYS_CLK or posedge RESET)
      if (RESET) beat_cnt <= 4'h0;
      else if (ARR_GROUP_END) beat_cnt <= 4'h0;
      else if (ARR_WR_STB) beat_cnt <= beat_cnt + 4'h1;
   sequence s_setup;
      PSEL && !PENABLE && CLK_EN;
   endsequence
   sequence s_unmapped;
      PADDR > ADDR_STATUS || PADDR[1:0] != 2'h0;
   endsequence
   AST_READY: assert property (PREADY == CLK_EN)
      else $error("ready does not follow clock enable");
   AST_UNMAPPED: assert property (s_setup ##0 s_unmapped |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (s_setup ##0 !(PADDR > ADDR_STATUS || PADDR[1:0] != 2'h0)
      |=> !PSLVERR) else $error("mapped access refused");
   AST_STB_PULSE: assert property (ARR_WR_STB |=> !ARR_WR_STB)
      else $error("array strobe longer than one cycle");
   AST_GROUP: assert property (ARR_GROUP_END |-> ARR_WR_STB && beat_cnt == 4'hF)
      else $error("group end not on sixteenth beat");
   AST_OPEN_BY_ACT: assert property ((|(BANK_OPEN & ~$past(BANK_OPEN)))
      |-> $past(CMD_CODE) == CMD_ACT && BANK_OPEN[$past(CMD_CA[2:0])])
      else $error("bank opened without activate");
   AST_ALL_CLOSE: assert property (($countones($past(BANK_OPEN) & ~BANK_OPEN) > 1)
      |-> $past(CMD_CODE) == CMD_PRE && $past(CMD_CA[5]))
      else $error("several banks closed without all-bank precharge");
   AST_MIV_OE: assert property (MIV_OE != 2'h0 |-> DQ_OE && MIV_OE == 2'h3)
      else $error("line driven outside a read burst");
endmodule
bind dmp_top dmp_props u_props (.SYS_CLK, .RESET, .CLK_EN, .PSEL, .PENABLE, .PADDR, .PRDATA,
   .PREADY, .PSLVERR, .CMD_CODE, .CMD_CA, .DQ_OE, .MIV_OE, .ARR_WR_STB, .ARR_GROUP_END,
   .BANK_OPEN);

/* File: tb/dmp_ctrl_model.sv */
// controller model: link clock, commands and write beats toward the device
`timescale 1ns/1ps
module dmp_ctrl_model
   import dmp_pkg::*;
(
   input  wire logic        SYS_CLK,
   output logic             LINK_CK,
   output logic [3:0]       CMD_CODE,
   output logic [5:0]       CMD_CA,
   output logic [15:0]      DQ_IN,
   output logic [1:0]       MIV_IN
);
   logic [15:0] dq_q [32];
   logic [1:0]  miv_q [32];
   // device clock runs free, phase unrelated to the system clock
   initial
   begin
      LINK_CK = 1'b0;
      CMD_CODE = CMD_NOP;
      CMD_CA = 6'h0;
      DQ_IN = 16'h0;
      MIV_IN = 2'h0;
      #37.3;
      forever #100 LINK_CK = ~LINK_CK;
   end
   // spacing between commands covers close, recovery and row cycle times
   task automatic gap(input int n);
      repeat (n) @(posedge LINK_CK);
      @(posedge SYS_CLK);
   endtask
   // one command held across its link edge, then n beats after write latency
   task automatic send(input dmp_cmd_t c, input logic [5:0] a, input int n);
      @(negedge LINK_CK);
      @(posedge SYS_CLK);
      CMD_CODE <= c;
      CMD_CA <= a;
      @(negedge LINK_CK);
      repeat (2) @(posedge SYS_CLK);
      CMD_CODE <= CMD_NOP;
      CMD_CA <= ~a;
      for (int i = 0; i < n; i++)
      begin
         // first beat stands on the edge after the last latency rise
         if (i == 0) repeat (TIMING_RST[3:0]) @(posedge LINK_CK);
         else @(LINK_CK);
         @(posedge SYS_CLK);
         DQ_IN <= dq_q[i];
         MIV_IN <= miv_q[i];
      end
      @(LINK_CK);
      @(posedge SYS_CLK);
      DQ_IN <= ~DQ_IN;
      MIV_IN <= ~MIV_IN;
   endtask
endmodule

/* File: tb/tb_dmp_top.sv */
// self-checking bench: registers, write mask/inversion, reads, training, bank closing
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_dmp_top;
   import dmp_pkg::*;
   logic SYS_CLK, RESET, CLK_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [7:0]  PADDR, BANK_OPEN;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0]  PSTRB, CMD_CODE;
   logic [5:0]  CMD_CA;
   logic [15:0] DQ_IN, DQ_OUT, dq_c, ARR_WR_DATA, ARR_RD_DATA;
   logic [1:0]  MIV_IN, MIV_OUT, MIV_OE, miv_c, ARR_WR_BE;
   logic [2:0]  ARR_WR_BANK;
   logic        LINK_CK, DQ_OE, MIV_RX_ON, ARR_WR_STB, ARR_GROUP_END, er;
   logic [20:0] stq [$];
   int          error_cnt = 0, total_checks = 0, cyc = 0;
   // wire level from every driver of the shared lines
   assign DQ_IN = DQ_OE ? DQ_OUT : dq_c;
   assign MIV_IN = (MIV_OE & MIV_OUT) | (~MIV_OE & miv_c);
   dmp_top dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_CK(LINK_CK),
      .CMD_CODE(CMD_CODE), .CMD_CA(CMD_CA), .DQ_IN(DQ_IN), .MIV_IN(MIV_IN), .DQ_OUT(DQ_OUT),
      .DQ_OE(DQ_OE), .MIV_OUT(MIV_OUT), .MIV_OE(MIV_OE), .MIV_RX_ON(MIV_RX_ON),
      .ARR_WR_STB(ARR_WR_STB), .ARR_WR_DATA(ARR_WR_DATA), .ARR_WR_BE(ARR_WR_BE),
      .ARR_WR_BANK(ARR_WR_BANK), .ARR_GROUP_END(ARR_GROUP_END), .ARR_RD_DATA(ARR_RD_DATA),
      .BANK_OPEN(BANK_OPEN));
   dmp_ctrl_model ctl (.SYS_CLK(SYS_CLK), .LINK_CK(LINK_CK), .CMD_CODE(CMD_CODE),
      .CMD_CA(CMD_CA), .DQ_IN(dq_c), .MIV_IN(miv_c));
   initial
   begin
      SYS_CLK = 1'b0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end
   // stored array beats and hang guard
   always @(posedge SYS_CLK)
   begin
      if (ARR_WR_STB === 1'b1) stq.push_back({ARR_WR_BANK, ARR_WR_BE, ARR_WR_DATA});
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one apb transfer, entered right after a rising edge, one idle cycle after it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic modes(input logic [7:0] m3, input logic [7:0] m13, input logic [7:0] m1);
      apb(1'b1, ADDR_MODE3, {24'h0, m3});
      apb(1'b1, ADDR_MODE13, {24'h0, m13});
      apb(1'b1, ADDR_MODE1, {24'h0, m1});
   endtask
   task automatic wait_oe();
      int n = 0;
      while (DQ_OE !== 1'b1 && n < 400) begin @(posedge SYS_CLK); n++; end
      if (n >= 400) error_cnt++;
      // first beat loads one link half period after the enable; look between edges
      repeat (5) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
   endtask
   // stored lane {enable, data} for the chosen write functions
   function automatic logic [8:0] lexp(logic [7:0] d, logic m, logic wi, logic mw);
      if (mw && (wi ? (!m && $countones(d[7:2]) >= 5) : m)) return {1'b0, d};
      return {1'b1, (wi && m) ? ~d : d};
   endfunction
   task automatic t_regs();
      logic [7:0]  ad [5] = '{ADDR_MODE3, ADDR_MODE13, ADDR_TIMING, ADDR_MODE1, ADDR_STATUS};
      logic [31:0] ex [5] = '{32'h0, 32'h0, TIMING_RST, 32'h0, 32'h0};
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
      // byte strobes: only the selected bytes of the timing word change
      PSTRB <= 4'h5;
      apb(1'b1, ADDR_TIMING, 32'h0);
      PSTRB <= 4'hA;
      apb(1'b1, ADDR_TIMING, 32'hFFFF_FFFF);
      PSTRB <= 4'hF;
      apb(1'b0, ADDR_TIMING, 32'h0);
      `CHK(rd, 32'hFF00_FF00)
      apb(1'b1, ADDR_TIMING, TIMING_RST);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, (i < 5) ? ad[i] : 8'hFF, 32'h0);
         `CHK(rd, (i < 5) ? ex[i] : 32'h0)
         `CHK(er, 1'(i == 5))
      end
      $display("test regs done");
   endtask
   task automatic t_pre();
      for (int b = 0; b < 8; b++) ctl.send(CMD_ACT, 6'(b), 0);
      ctl.gap(2);
      `CHK(BANK_OPEN, 8'hFF)
      // clock enable low: a precharge on the pins meanwhile is never seen
      CLK_EN <= 1'b0;
      ctl.send(CMD_PRE, 6'h20, 0);
      CLK_EN <= 1'b1;
      ctl.gap(2);
      `CHK(BANK_OPEN, 8'hFF)
      ctl.send(CMD_PRE, 6'h03, 0);
      ctl.gap(2);
      `CHK(BANK_OPEN, 8'hF7)
      ctl.send(CMD_PRE, 6'h25, 0);
      ctl.gap(2);
      `CHK(BANK_OPEN, 8'h00)
      $display("test precharge done");
   endtask
   task automatic t_write(input logic wi, input logic mk, input logic mw, input logic lo);
      logic [15:0] d;
      logic [1:0]  m;
      logic [8:0]  e0, e1;
      modes({wi, 7'h0}, {2'h0, mk, 5'h0}, 8'h0);
      `CHK(MIV_RX_ON, wi | mk)
      for (int i = 0; i < 16; i++)
      begin
         ctl.dq_q[i] = i[0] ? 16'h0FFC : 16'hA53A ^ 16'(i);
         ctl.miv_q[i] = lo ? 2'h0 : (mw && !wi) ? {~i[2], i[2]} : {i[1], i[0] ^ i[2]};
      end
      ctl.send(CMD_ACT, 6'h01, 0);
      ctl.gap(4);
      stq.delete();
      ctl.send(mw ? CMD_MWR : CMD_WR, 6'h01, 16);
      ctl.gap(24);
      `CHK(stq.size(), 16)
      foreach (stq[i])
      begin
         d = ctl.dq_q[i];
         m = ctl.miv_q[i];
         e0 = lexp(d[7:0], m[0], wi, mw);
         e1 = lexp(d[15:8], m[1], wi, mw);
         `CHK(stq[i][20:16], {3'h1, e1[8], e0[8]})
         `CHK(stq[i][15:0] & {{8{e1[8]}}, {8{e0[8]}}},
            {e1[7:0] & {8{e1[8]}}, e0[7:0] & {8{e0[8]}}})
      end
      ctl.send(CMD_PRE, 6'h01, 0);
      ctl.gap(8);
      $display("test write %0d%0d%0d done", wi, mk, mw);
   endtask
   task automatic t_read();
      modes(8'h40, 8'h0, 8'h0);
      ARR_RD_DATA <= 16'h1F03;
      ctl.send(CMD_ACT, 6'h02, 0);
      ctl.gap(4);
      ctl.send(CMD_RD, 6'h02, 0);
      wait_oe();
      `CHK({MIV_OE, MIV_OUT, DQ_OUT}, {2'h3, 2'h2, 16'hE003})
      ctl.gap(20);
      ctl.send(CMD_MRR, 6'h0, 0);
      wait_oe();
      `CHK({MIV_OE, MIV_OUT, DQ_OUT}, {2'h3, 2'h2, 16'hE003})
      ctl.gap(20);
      modes(8'h0, 8'h0, 8'h0);
      for (int i = 0; i < 16; i++) ctl.miv_q[i] = 2'h1;
      stq.delete();
      ctl.send(CMD_WFIFO, 6'h0, 16);
      ctl.gap(20);
      `CHK(stq.size(), 0)
      ARR_RD_DATA <= 16'hE0FC;
      ctl.send(CMD_RFIFO, 6'h0, 0);
      wait_oe();
      `CHK({MIV_OE, MIV_OUT, DQ_OUT}, {2'h3, 2'h1, 16'hE0FC})
      ctl.gap(20);
      $display("test read done");
   endtask
   task automatic t_auto();
      ctl.send(CMD_ACT, 6'h06, 0);
      ctl.gap(5);
      ctl.send(CMD_RD, 6'h06, 0);
      ctl.gap(30);
      `CHK(BANK_OPEN[6], 1'b1)
      for (int b = 0; b < 2; b++)
      begin
         modes(8'h0, 8'h0, 8'(b));
         ctl.send(CMD_ACT, 6'h04, 0);
         ctl.gap(5);
         ctl.send(CMD_RD, 6'h24, 0);
         ctl.gap(5 + 8 * b);
         `CHK(BANK_OPEN[4], 1'b1)
         ctl.gap(5);
         `CHK(BANK_OPEN[4], 1'b0)
         ctl.gap(30);
      end
      $display("test auto-close done");
   endtask
   initial
   begin
      logic [3:0] rows [5] = '{4'h0, 4'h8, 4'h5, 4'h6, 4'hE};
      RESET = 1'b1;
      CLK_EN = 1'b1;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 8'h0;
      PWDATA = 32'h0;
      PSTRB = 4'hF;
      ARR_RD_DATA = 16'h0;
      repeat (20) @(posedge SYS_CLK);
      RESET <= 1'b0;
      @(posedge SYS_CLK);
      t_regs();
      t_pre();
      foreach (rows[k]) t_write(rows[k][3], rows[k][2], rows[k][1], rows[k][0]);
      t_read();
      t_auto();
      conclude();
   end
endmodule
